// ### verilog/sync_tx_message_framing.sv
// How it works
// - End request finishes the message, manner set by protocol and run bit.
// - Character protocol always goes idle after the check word.
// - Bit protocol goes idle or idles flags after the check word.
// - Flags repeat until end request clears and new data arrives.
// - Check register holds all zeros or all ones after check word.
// - End request is read/write and cleared by reset.
// - Start request begins a message only while transmitter idle.
// - Start request re-initialises the check register.
// - Re-init and first bit out within two bit times.
// - Character mode repeats the sync byte while start stays set.
// - Preamble characters are kept out of the check register.
// - Clearing start finishes the current sync, then data follows.
// - Every data character feeds the check register.
// - Bit mode sends flags while start set, data after current flag.
// - Setting start clears the underrun flag.
// - Character-done raised after each flag or sync with start set.
// - Data is eight-bit characters, bit 0 least significant.
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module sync_tx_message_framing (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial line
  output logic tx_serial_out,
  output logic tx_active
);
  import framer_pkg::*;

  // ============================================================
  // State
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [3:0] awaddr_r, awaddr_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [1:0] wstrb_r, wstrb_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  tx_state_t state_r, state_nxt;
  ctrl_t ctrl_r, ctrl_nxt;
  logic [15:0] shift_r, shift_nxt, crc_r, crc_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [6:0] div_r, div_nxt;
  logic [7:0] buf_r, buf_nxt;
  logic full_r, full_nxt, som_r, som_nxt, eom_r, eom_nxt;
  logic done_r, done_nxt, undr_r, undr_nxt;
  logic start_r, start_nxt, feed_r, feed_nxt;
  logic line_r, line_nxt, active_r;
  logic tick, wr_do, char_end, buf_wr;
  logic [15:0] crc_upd;

  assign tick = (div_r == BIT_LAST);
  assign wr_do = aw_got_r && w_got_r && !bvalid_r;
  // Byte landing as the old one is taken keeps the buffer full
  assign buf_wr = wr_do && awaddr_r == OFF_BUF && wstrb_r[0];
  assign char_end = tick && (state_r != ST_IDLE) &&
                    (cnt_r == ((state_r == ST_CHECK) ? CHECK_LAST
                                                    : CHAR_LAST));
  assign crc_upd = crc_step(crc_r, shift_r[0], ctrl_r.char_mode);

  // ============================================================
  // Bus slave: capture address and data in either order
  always_comb begin
    aw_got_nxt = aw_got_r;
    awaddr_nxt = awaddr_r;
    w_got_nxt = w_got_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_awvalid && awready_r) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata[15:0];
      wstrb_nxt = s_axi_wstrb[1:0];
    end
    // Response only after both halves are in
    if (wr_do) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (awaddr_r == OFF_BUF || awaddr_r == OFF_CTRL ||
                   awaddr_r == OFF_STAT) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    // Read data sampled at the address handshake
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      unique case (s_axi_araddr)
        OFF_BUF: begin
          rdata_nxt[7:0] = buf_r;
          rdata_nxt[BUF_SOM_BIT] = som_r;
          rdata_nxt[BUF_EOM_BIT] = eom_r;
        end
        OFF_CTRL: begin
          rdata_nxt[CTRL_RUN_BIT] = ctrl_r.run;
          rdata_nxt[CTRL_CHAR_BIT] = ctrl_r.char_mode;
        end
        OFF_STAT: begin
          rdata_nxt[STAT_ACT_BIT] = active_r;
          rdata_nxt[STAT_DONE_BIT] = done_r;
          rdata_nxt[STAT_UNDR_BIT] = undr_r;
          rdata_nxt[STAT_FULL_BIT] = full_r;
        end
        default: rresp_nxt = RESP_SLVERR;
      endcase
    end
    // One write and one read in flight at most
    awready_nxt = !aw_got_nxt && !bvalid_nxt;
    wready_nxt = !w_got_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  // ============================================================
  // Framer: register effects and character sequencing
  always_comb begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    shift_nxt = shift_r;
    crc_nxt = crc_r;
    cnt_nxt = cnt_r;
    div_nxt = tick ? 7'h00 : 7'(div_r + 7'h01);
    buf_nxt = buf_r;
    full_nxt = full_r;
    som_nxt = som_r;
    eom_nxt = eom_r;
    done_nxt = done_r;
    undr_nxt = undr_r;
    start_nxt = start_r;
    feed_nxt = feed_r;
    line_nxt = line_r;
    // Register writes; hardware sets below override the clears
    if (wr_do && awaddr_r == OFF_BUF) begin
      if (wstrb_r[0]) begin
        buf_nxt = wdata_r[7:0];
        full_nxt = 1'b1;
        done_nxt = 1'b0;
      end
      if (wstrb_r[1]) begin
        eom_nxt = wdata_r[BUF_EOM_BIT];
        som_nxt = wdata_r[BUF_SOM_BIT];
        if (wdata_r[BUF_SOM_BIT] && !som_r && state_r == ST_IDLE) begin
          start_nxt = 1'b1;
          crc_nxt = crc_preset(ctrl_r.char_mode);
          undr_nxt = 1'b0;
        end
      end
    end
    if (wr_do && awaddr_r == OFF_CTRL && wstrb_r[0]) begin
      ctrl_nxt.run = wdata_r[CTRL_RUN_BIT];
      ctrl_nxt.char_mode = wdata_r[CTRL_CHAR_BIT];
    end
    // Bit time: one bit leaves, maybe a new character loads
    if (tick) begin
      if (state_r == ST_IDLE) begin
        line_nxt = 1'b1;
        // first bit at the next tick
        if (start_r) begin
          start_nxt = 1'b0;
          state_nxt = ST_PRE;
          cnt_nxt = 4'h0;
          shift_nxt = {8'h00, ctrl_r.char_mode ? buf_r : FLAG_CHAR};
          full_nxt = buf_wr;
        end
      end else begin
        line_nxt = shift_r[0];
        shift_nxt = {1'b0, shift_r[15:1]};
        cnt_nxt = 4'(cnt_r + 4'h1);
        if (state_r == ST_DATA && feed_r) begin
          crc_nxt = crc_upd;
        end
        // fill check register while sending it
        if (state_r == ST_CHECK) begin
          crc_nxt = {!ctrl_r.char_mode, crc_r[15:1]};
        end
      end
    end
    if (char_end) begin
      cnt_nxt = 4'h0;
      unique case (state_r)
        ST_PRE, ST_DATA: begin
          if (state_r == ST_PRE && som_r) begin
            shift_nxt = {8'h00, ctrl_r.char_mode ? buf_r : FLAG_CHAR};
            done_nxt = 1'b1;
          end else if (full_r) begin
            state_nxt = ST_DATA;
            shift_nxt = {8'h00, buf_r};
            full_nxt = buf_wr;
            done_nxt = 1'b1;
            feed_nxt = 1'b1;
          end else if (eom_r) begin
            state_nxt = ST_CHECK;
            shift_nxt = ctrl_r.char_mode ? crc_r : ~crc_r;
            if (state_r == ST_DATA && feed_r) begin
              shift_nxt = ctrl_r.char_mode ? crc_upd : ~crc_upd;
              crc_nxt = crc_upd;
            end
          end else begin
            // Starved: pad character kept out of the check
            state_nxt = ST_DATA;
            shift_nxt = {8'h00, FILL_CHAR};
            undr_nxt = 1'b1;
            feed_nxt = 1'b0;
          end
        end
        ST_CHECK: begin
          if (ctrl_r.char_mode || !ctrl_r.run) begin
            state_nxt = ST_IDLE;
          end else begin
            state_nxt = ST_FLAGS;
            shift_nxt = {8'h00, FLAG_CHAR};
          end
        end
        ST_FLAGS: begin
          // flags until new data and end cleared
          if (!eom_r && full_r) begin
            state_nxt = ST_DATA;
            shift_nxt = {8'h00, buf_r};
            crc_nxt = crc_preset(ctrl_r.char_mode);
            full_nxt = buf_wr;
            done_nxt = 1'b1;
            feed_nxt = 1'b1;
          end else begin
            shift_nxt = {8'h00, FLAG_CHAR};
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // ============================================================
  // Registers; synchronous reset clears everything, sets the line high and the state to idle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_got_r <= 1'b0;
      awaddr_r <= 4'h0;
      w_got_r <= 1'b0;
      wdata_r <= 16'h0000;
      wstrb_r <= 2'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      state_r <= ST_IDLE;
      ctrl_r <= '0;
      shift_r <= 16'h0000;
      crc_r <= CRC_ZEROS;
      cnt_r <= 4'h0;
      div_r <= 7'h00;
      buf_r <= BUF_RESET;
      full_r <= 1'b0;
      som_r <= 1'b0;
      eom_r <= 1'b0;
      done_r <= 1'b0;
      undr_r <= 1'b0;
      start_r <= 1'b0;
      feed_r <= 1'b0;
      line_r <= 1'b1;
      active_r <= 1'b0;
    end else begin
      aw_got_r <= aw_got_nxt;
      awaddr_r <= awaddr_nxt;
      w_got_r <= w_got_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      shift_r <= shift_nxt;
      crc_r <= crc_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      buf_r <= buf_nxt;
      full_r <= full_nxt;
      som_r <= som_nxt;
      eom_r <= eom_nxt;
      done_r <= done_nxt;
      undr_r <= undr_nxt;
      start_r <= start_nxt;
      feed_r <= feed_nxt;
      line_r <= line_nxt;
      active_r <= (state_nxt != ST_IDLE);
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign tx_serial_out = line_r;
  assign tx_active = active_r;

  // ============================================================
  // Checks
  localparam int START_MAX = 2 * BIT_CYC;
  logic check_end;
  assign check_end = char_end && state_r == ST_CHECK;

  property p_eom_rw;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_do && awaddr_r == OFF_BUF && wstrb_r[1])
        |=> (eom_r == $past(wdata_r[BUF_EOM_BIT]));
  endproperty
  a_eom_rw: assert property (p_eom_rw)
    else $error("end request not stored");
  property p_start_idle;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(start_r) |-> $past(state_r == ST_IDLE);
  endproperty
  a_start_idle: assert property (p_start_idle)
    else $error("start taken while active");
  property p_crc_init;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(start_r) |-> (crc_r == crc_preset(ctrl_r.char_mode));
  endproperty
  a_crc_init: assert property (p_crc_init)
    else $error("check register not preset at start");
  property p_first_bit;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(start_r) |-> ##[1:START_MAX] (state_r == ST_PRE);
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("first bit late");
  property p_char_idle;
    @(posedge sys_clk) disable iff (!rst_n)
      (check_end && ctrl_r.char_mode) |=> (state_r == ST_IDLE);
  endproperty
  a_char_idle: assert property (p_char_idle)
    else $error("character mode did not idle");
  property p_flag_idle;
    @(posedge sys_clk) disable iff (!rst_n)
      (check_end && !ctrl_r.char_mode && ctrl_r.run)
        |=> (state_r == ST_FLAGS && shift_r[7:0] == FLAG_CHAR);
  endproperty
  a_flag_idle: assert property (p_flag_idle)
    else $error("flag idling not entered");
  property p_crc_end;
    @(posedge sys_clk) disable iff (!rst_n)
      check_end |=> (crc_r == CRC_ZEROS || crc_r == CRC_ONES);
  endproperty
  a_crc_end: assert property (p_crc_end)
    else $error("check register not flat after check word");
  property p_pre_excluded;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_r == ST_PRE && !char_end) |=> $stable(crc_r);
  endproperty
  a_pre_excluded: assert property (p_pre_excluded)
    else $error("preamble changed check register");
  property p_undr_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(start_r) |-> !undr_r;
  endproperty
  a_undr_clear: assert property (p_undr_clear)
    else $error("underrun not cleared by start");
  property p_active;
    @(posedge sys_clk) disable iff (!rst_n)
      (check_end && (ctrl_r.char_mode || !ctrl_r.run)) |=> !tx_active;
  endproperty
  a_active: assert property (p_active)
    else $error("active flag still high after going idle");

  c_start: cover property (@(posedge sys_clk) $rose(start_r));
  c_flags: cover property (@(posedge sys_clk) $rose(state_r == ST_FLAGS));
  c_done_idle: cover property (@(posedge sys_clk)
    check_end ##1 state_r == ST_IDLE);
endmodule : sync_tx_message_framing

// ### verilog/framer_pkg.sv
// ============================================================
// Shared constants and types for the message framer
package framer_pkg;
  // ============================================================
  // Timing
  localparam int CLK_NS = 10;
  localparam int BIT_NS = 1000;
  localparam int BIT_CYC = (BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0] BIT_LAST = 7'(BIT_CYC - 1);
  // ============================================================
  // Register offsets (byte addresses)
  localparam logic [3:0] OFF_BUF = 4'h0;
  localparam logic [3:0] OFF_CTRL = 4'h4;
  localparam logic [3:0] OFF_STAT = 4'h8;
  // ============================================================
  // Field positions
  localparam int BUF_SOM_BIT = 8;
  localparam int BUF_EOM_BIT = 9;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CHAR_BIT = 1;
  localparam int STAT_ACT_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_UNDR_BIT = 2;
  localparam int STAT_FULL_BIT = 3;
  // ============================================================
  // Reset values and codes
  localparam logic [7:0] BUF_RESET = 8'h00;
  localparam logic [7:0] FLAG_CHAR = 8'h7E;
  localparam logic [7:0] FILL_CHAR = 8'hFF;
  localparam logic [15:0] POLY_CHAR = 16'hA001;
  localparam logic [15:0] POLY_BIT = 16'h8408;
  localparam logic [15:0] CRC_ZEROS = 16'h0000;
  localparam logic [15:0] CRC_ONES = 16'hFFFF;
  localparam logic [3:0] CHAR_LAST = 4'h7;
  localparam logic [3:0] CHECK_LAST = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PRE = 5'b00010,
    ST_DATA = 5'b00100,
    ST_CHECK = 5'b01000,
    ST_FLAGS = 5'b10000
  } tx_state_t;

  typedef struct packed {
    logic char_mode;
    logic run;
  } ctrl_t;

  // One serial step of the reflected CRC
  function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                           input logic din,
                                           input logic char_mode);
    logic fb;
    fb = crc[0] ^ din;
    crc_step = {1'b0, crc[15:1]} ^
               (fb ? (char_mode ? POLY_CHAR : POLY_BIT) : CRC_ZEROS);
  endfunction : crc_step

  // Preset value depends on the protocol
  function automatic logic [15:0] crc_preset(input logic char_mode);
    crc_preset = char_mode ? CRC_ZEROS : CRC_ONES;
  endfunction : crc_preset
endpackage : framer_pkg

// ### sim/line_monitor.sv
`timescale 1ns/10ps
// ============================================================
// Far-end receiver: samples the line mid-bit, resyncs on edges
module line_monitor
  import framer_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control and line
  input wire logic clr,
  input wire logic line_in
);
  logic prev_r = 1'b1;
  logic started_r = 1'b0;
  int ph_r = 0;
  logic bits_q[$];
  // Mid-bit sampling keeps clear of the tick where the line moves
  // LSB first capture
  always @(posedge sys_clk) begin
    prev_r <= line_in;
    if (!rst_n || clr) begin
      started_r <= 1'b0;
      bits_q.delete();
    end else if (line_in !== prev_r) begin
      started_r <= 1'b1;
      ph_r <= BIT_CYC / 2 - 1;
    end else if (started_r) begin
      if (ph_r == 0) begin
        bits_q.push_back(line_in);
        ph_r <= BIT_CYC - 1;
      end else begin
        ph_r <= ph_r - 1;
      end
    end
  end
endmodule : line_monitor

// ### sim/tb_top.sv
`timescale 1ns/10ps
// ============================================================
// Bench for the message framer
module tb_top;
  import framer_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic tx_serial_out;
  logic tx_active;
  logic mon_clr = 1'b0;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int idx;
  logic [31:0] d;
  logic [1:0] r;

  sync_tx_message_framing dut_u (.sys_clk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_serial_out, .tx_active);
  line_monitor mon_u (.sys_clk, .rst_n, .clr(mon_clr),
    .line_in(tx_serial_out));

  always #(CLK_NS / 2) sys_clk = ~sys_clk;

  // ============================================================
  // Checking and closing
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Ceiling well above the longest expected run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 80000) begin
      failures++;
      $display("[FAIL] timeout reached");
      complete_run();
    end
  end

  // ============================================================
  // Bus tasks: hold each channel until its own ready
  task automatic wr(input logic [3:0] a, input logic [15:0] v,
                    input logic [1:0] s);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, v};
    s_axi_wstrb <= {2'b00, s};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge sys_clk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd

  // ============================================================
  // Line decoding and expected check word
  function automatic logic [7:0] get_byte(input int i);
    for (int k = 0; k < 8; k++)
      get_byte[k] = (i + k < mon_u.bits_q.size()) ?
                    mon_u.bits_q[i + k] : 1'bx;
  endfunction : get_byte

  task automatic skip(input logic [7:0] b, output int n);
    n = 0;
    while (get_byte(idx) === b) begin
      n++;
      idx += 8;
    end
  endtask : skip

  task automatic exp_byte(input string nm, input logic [7:0] e);
    chk(nm, {24'h0, get_byte(idx)}, {24'h0, e});
    idx += 8;
  endtask : exp_byte

  function automatic logic [15:0] crc8(input logic [15:0] c,
                                       input logic [15:0] p,
                                       input logic [7:0] v);
    logic fb;
    for (int k = 0; k < 8; k++) begin
      fb = c[0] ^ v[k];
      c = {1'b0, c[15:1]} ^ (fb ? p : 16'h0000);
    end
    return c;
  endfunction : crc8

  // Clear the monitor, then wait out a message and trailing idle
  task automatic clr_mon;
    @(posedge sys_clk);
    mon_clr <= 1'b1;
    @(posedge sys_clk);
    mon_clr <= 1'b0;
  endtask : clr_mon

  task automatic wait_idle;
    while (tx_active !== 1'b0) @(posedge sys_clk);
    repeat (9 * BIT_CYC) @(posedge sys_clk);
    idx = 0;
  endtask : wait_idle

  // ============================================================
  // Scenarios
  task automatic t_reset;
    chk("line_idle", {31'h0, tx_serial_out}, 32'h1);
    rd(OFF_BUF);
    chk("buf_reset", d, 32'h0);
    rd(OFF_STAT);
    chk("stat_reset", d, 32'h0);
    rd(4'hC);
    chk("unmapped_resp", {30'h0, r}, {30'h0, RESP_SLVERR});
  endtask : t_reset

  task automatic t_bit(input logic run);
    int n;
    logic [15:0] c;
    wr(OFF_CTRL, {15'h0, run}, 2'b01);
    clr_mon();
    wr(OFF_BUF, 16'h0100, 2'b11);
    n = 0;
    while (tx_serial_out !== 1'b0) begin
      @(posedge sys_clk);
      n++;
    end
    chk("first_bit", {31'h0, n <= 2 * BIT_CYC}, 32'h1);
    repeat (10 * BIT_CYC) @(posedge sys_clk);
    rd(OFF_STAT);
    chk("active", {31'h0, d[STAT_ACT_BIT]}, 32'h1);
    chk("done_flag", {31'h0, d[STAT_DONE_BIT]}, 32'h1);
    wr(OFF_BUF, 16'h00A5, 2'b11);
    if (!run) begin
      repeat (18 * BIT_CYC) @(posedge sys_clk);
      rd(OFF_STAT);
      chk("underrun", {31'h0, d[STAT_UNDR_BIT]}, 32'h1);
    end
    wr(OFF_BUF, 16'h0200, 2'b10);
    rd(OFF_BUF);
    chk("eom_read", {31'h0, d[BUF_EOM_BIT]}, 32'h1);
    if (run) begin
      // Long enough for at least two idle flags
      repeat (46 * BIT_CYC) @(posedge sys_clk);
      chk("flag_idle_active", {31'h0, tx_active}, 32'h1);
      wr(OFF_BUF, 16'h003C, 2'b11);
      wr(OFF_CTRL, 16'h0000, 2'b01);
      // End request only once the new byte has left the buffer
      do rd(OFF_STAT); while (d[STAT_FULL_BIT] !== 1'b0);
      chk("taken_done", {31'h0, d[STAT_DONE_BIT]}, 32'h1);
      wr(OFF_BUF, 16'h0200, 2'b10);
    end
    wait_idle();
    skip(FLAG_CHAR, n);
    chk("flags", {31'h0, n > 0}, 32'h1);
    exp_byte("data_a5", 8'hA5);
    if (!run) skip(FILL_CHAR, n);
    c = ~crc8(CRC_ONES, POLY_BIT, 8'hA5);
    exp_byte("check_lo", c[7:0]);
    exp_byte("check_hi", c[15:8]);
    if (run) begin
      skip(FLAG_CHAR, n);
      chk("idle_flags", {31'h0, n > 1}, 32'h1);
      exp_byte("data_3c", 8'h3C);
      c = ~crc8(CRC_ONES, POLY_BIT, 8'h3C);
      exp_byte("check2_lo", c[7:0]);
      exp_byte("check2_hi", c[15:8]);
    end
    exp_byte("idle_line", 8'hFF);
  endtask : t_bit

  task automatic t_char;
    int n;
    logic [15:0] c;
    rd(OFF_STAT);
    chk("underrun_pre", {31'h0, d[STAT_UNDR_BIT]}, 32'h1);
    wr(OFF_CTRL, 16'h0003, 2'b01);
    clr_mon();
    wr(OFF_BUF, 16'h0116, 2'b11);
    repeat (20 * BIT_CYC) @(posedge sys_clk);
    rd(OFF_STAT);
    chk("underrun_clr", {31'h0, d[STAT_UNDR_BIT]}, 32'h0);
    chk("sync_done", {31'h0, d[STAT_DONE_BIT]}, 32'h1);
    wr(OFF_BUF, 16'h00C3, 2'b11);
    wr(OFF_BUF, 16'h0200, 2'b10);
    wait_idle();
    skip(8'h16, n);
    chk("syncs", {31'h0, n > 1}, 32'h1);
    exp_byte("data_c3", 8'hC3);
    c = crc8(CRC_ZEROS, POLY_CHAR, 8'hC3);
    exp_byte("ccheck_lo", c[7:0]);
    exp_byte("ccheck_hi", c[15:8]);
    exp_byte("cidle_line", 8'hFF);
  endtask : t_char

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_bit(1'b1);
    t_bit(1'b0);
    t_char();
    complete_run();
  end
endmodule : tb_top
